// ==== rtl/mcct_top.v ====
// What this block does
// - Each timer has a counter of 32 or 16 bits behind a prescaler of the same width.
// - A timer advances either on its prescaled clock or on edges of its capture pin.
// - A selected edge of the capture pin copies the counter into the capture register.
// - A capture event can raise the interrupt when its enable bit is set.
// - Four match values per timer flag an event and may interrupt while counting goes on.
// - Each match can stop the counter, independently of its interrupt enable.
// - Each match can return the counter to zero, independently of its interrupt enable.
// - Each match drives its output low, high, toggled or unchanged.
// - A chosen capture-pin edge can clear both counter and prescaler.
// - In timer mode the counter counts prescaler ticks, one every pre_max+1 cycles of the system clock.
// - Two timers have 32-bit counters and two have 16-bit counters.
`include "mcct_consts.vh"
module mcct_top (
    // Clock and reset
    input wire sys_clk,
    input wire rst_b,
    // Register port
    input wire [`MCCT_AW-1:0] reg_addr,
    input wire [`MCCT_DW-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`MCCT_DW-1:0] reg_rdata_r,
    // Capture pins, one per timer
    input wire [3:0] cap_pin,
    // Match output pins, four per timer
    output wire [15:0] match_pin,
    // Interrupt
    output reg irq_r
);
    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    reg rst_s1_r;
    reg rst_s2_r;

    // Two-stage reset synchroniser
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    wire rst_n = rst_s2_r;

    ////////////////////////////////////////////////////////////////////////////
    // Capture pin synchronisers
    reg [3:0] cap_s1_r;
    reg [3:0] cap_s2_r;

    // Two flops before any logic
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_s1_r <= 4'h0;
            cap_s2_r <= 4'h0;
        end else begin
            cap_s1_r <= cap_pin;
            cap_s2_r <= cap_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    reg [`MCCT_CTRL_W-1:0] ctrl_r [0:3];
    reg [`MCCT_MCTL_W-1:0] mctl_r [0:3];
    reg [`MCCT_DW-1:0] pre_max_r [0:3];
    reg [`MCCT_DW-1:0] match_r [0:15];
    reg [`MCCT_IRQ_W-1:0] int_stat_r;
    reg [`MCCT_IRQ_W-1:0] int_en_r;

    // Address decode
    wire glob_sel = reg_addr[8];
    wire [1:0] tsel = reg_addr[7:6];
    wire [3:0] rsel = reg_addr[5:2];
    wire tmr_sel = ~reg_addr[8] & (reg_addr[11:9] == 3'h0);

    // Events from the timers
    wire [3:0] stop_ev;
    wire [`MCCT_IRQ_W-1:0] ev_vec;

    ////////////////////////////////////////////////////////////////////////////
    // Software writes and hardware stop
    integer t;
    integer k;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (t = 0; t < 4; t = t + 1) begin
                ctrl_r[t] <= `MCCT_RST_CTRL;
                mctl_r[t] <= `MCCT_RST_MCTL;
                pre_max_r[t] <= `MCCT_RST_WORD;
            end
            for (k = 0; k < 16; k = k + 1) begin
                match_r[k] <= `MCCT_RST_WORD;
            end
        end else begin
            // A stop match drops the run bit
            for (t = 0; t < 4; t = t + 1) begin
                if (stop_ev[t]) begin
                    ctrl_r[t][`MCCT_CTRL_RUN] <= 1'b0;
                end
            end
            if (reg_wr && tmr_sel) begin
                case (rsel)
                    `MCCT_OFS_CTRL: ctrl_r[tsel] <= reg_wdata[`MCCT_CTRL_W-1:0];
                    `MCCT_OFS_PRESCALE: pre_max_r[tsel] <= reg_wdata;
                    `MCCT_OFS_MATCH_CTRL: mctl_r[tsel] <= reg_wdata[`MCCT_MCTL_W-1:0];
                    4'h6, 4'h7, 4'h8, 4'h9: match_r[{tsel, rsel[1:0] - 2'h2}] <= reg_wdata;
                    default: ;
                endcase
            end
            // Soft reset bit is self-clearing
            for (t = 0; t < 4; t = t + 1) begin
                if (ctrl_r[t][`MCCT_CTRL_SOFT_RST] && !(reg_wr && tmr_sel && tsel == t[1:0])) begin
                    ctrl_r[t][`MCCT_CTRL_SOFT_RST] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer instances
    wire [127:0] pre_flat;
    wire [127:0] cnt_flat;
    wire [127:0] cap_flat;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_tmr
            // First two timers wide, last two narrow
            localparam integer TW = (g < 2) ? `MCCT_W_WIDE : `MCCT_W_NARROW;
            wire [4*TW-1:0] mv;
            wire [3:0] mev;
            wire cev;
            assign mv = {match_r[4*g+3][TW-1:0], match_r[4*g+2][TW-1:0],
                         match_r[4*g+1][TW-1:0], match_r[4*g][TW-1:0]};
            assign ev_vec[`MCCT_IRQ_PER_TMR*g +: `MCCT_IRQ_PER_TMR] = {cev, mev};
            mcct_core #(
                .W(TW)
            ) u_core (
                .clk(sys_clk),
                .rst_n(rst_n),
                .run(ctrl_r[g][`MCCT_CTRL_RUN]),
                .cnt_mode(ctrl_r[g][`MCCT_CTRL_CNT_MODE]),
                .cnt_edge(ctrl_r[g][`MCCT_CTRL_CNT_EDGE +: 2]),
                .cap_edge(ctrl_r[g][`MCCT_CTRL_CAP_EDGE +: 2]),
                .clr_edge(ctrl_r[g][`MCCT_CTRL_CLR_EDGE +: 2]),
                .soft_rst(ctrl_r[g][`MCCT_CTRL_SOFT_RST]),
                .pre_max(pre_max_r[g][TW-1:0]),
                .stop_en(mctl_r[g][`MCCT_MCTL_STOP +: 4]),
                .reset_en(mctl_r[g][`MCCT_MCTL_RESET +: 4]),
                .out_act(mctl_r[g][`MCCT_MCTL_OUT +: 8]),
                .match_val(mv),
                .cap_sync(cap_s2_r[g]),
                .pre_r(pre_flat[32*g +: TW]),
                .count_r(cnt_flat[32*g +: TW]),
                .capture_r(cap_flat[32*g +: TW]),
                .match_out_r(match_pin[4*g +: 4]),
                .match_ev_r(mev),
                .cap_ev_r(cev),
                .stop_ev_r(stop_ev[g])
            );
            // Narrow timers read zero above their width
            if (TW < 32) begin : g_pad
                assign pre_flat[32*g+TW +: 32-TW] = {(32-TW){1'b0}};
                assign cnt_flat[32*g+TW +: 32-TW] = {(32-TW){1'b0}};
                assign cap_flat[32*g+TW +: 32-TW] = {(32-TW){1'b0}};
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, enable and output
    wire clr_wr = reg_wr && (reg_addr == `MCCT_ADDR_INT_CLEAR);
    wire [`MCCT_IRQ_W-1:0] clr_mask = clr_wr ? reg_wdata[`MCCT_IRQ_W-1:0]
                                             : {`MCCT_IRQ_W{1'b0}};

    // Sticky status, a new event wins over a clear
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_stat_r <= {`MCCT_IRQ_W{1'b0}};
            int_en_r <= {`MCCT_IRQ_W{1'b0}};
            irq_r <= 1'b0;
        end else begin
            int_stat_r <= (int_stat_r & ~clr_mask) | ev_vec;
            if (reg_wr && reg_addr == `MCCT_ADDR_INT_ENABLE) begin
                int_en_r <= reg_wdata[`MCCT_IRQ_W-1:0];
            end
            irq_r <= |(int_stat_r & int_en_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data
    reg [`MCCT_DW-1:0] rd_nxt;

    // Upper two timers are narrow: stored words read back cut to their width
    wire [`MCCT_DW-1:0] rd_mask = tsel[1] ?
        {{(`MCCT_DW-`MCCT_W_NARROW){1'b0}}, {`MCCT_W_NARROW{1'b1}}} :
        {`MCCT_DW{1'b1}};

    // Read multiplexer
    always @* begin
        rd_nxt = `MCCT_RST_WORD;
        if (tmr_sel) begin
            case (rsel)
                `MCCT_OFS_CTRL: rd_nxt = {23'h000000, ctrl_r[tsel]};
                `MCCT_OFS_PRESCALE: rd_nxt = pre_max_r[tsel] & rd_mask;
                `MCCT_OFS_PRE_CNT: rd_nxt = pre_flat[32*tsel +: 32];
                `MCCT_OFS_COUNT: rd_nxt = cnt_flat[32*tsel +: 32];
                `MCCT_OFS_CAPTURE: rd_nxt = cap_flat[32*tsel +: 32];
                `MCCT_OFS_MATCH_CTRL: rd_nxt = {16'h0000, mctl_r[tsel]};
                4'h6, 4'h7, 4'h8, 4'h9: rd_nxt = match_r[{tsel, rsel[1:0] - 2'h2}] & rd_mask;
                default: rd_nxt = `MCCT_RST_WORD;
            endcase
        end else if (glob_sel && reg_addr == `MCCT_ADDR_INT_STATUS) begin
            rd_nxt = {12'h000, int_stat_r};
        end else if (glob_sel && reg_addr == `MCCT_ADDR_INT_ENABLE) begin
            rd_nxt = {12'h000, int_en_r};
        end
    end

    // Read data registered, one cycle after the strobe
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r <= `MCCT_RST_WORD;
        end else if (reg_rd) begin
            reg_rdata_r <= rd_nxt;
        end else begin
            reg_rdata_r <= `MCCT_RST_WORD;
        end
    end
endmodule

// ==== rtl/mcct_consts.vh ====
`ifndef MCCT_CONSTS_VH
`define MCCT_CONSTS_VH
// Timer geometry
`define MCCT_N_TIMERS 4
`define MCCT_N_MATCH 4
`define MCCT_W_WIDE 32
`define MCCT_W_NARROW 16
// Register bus geometry
`define MCCT_AW 12
`define MCCT_DW 32
// Per-timer block: base = timer index * 0x40
`define MCCT_TMR_BLK_LSB 6
`define MCCT_OFS_CTRL 4'h0
`define MCCT_OFS_PRESCALE 4'h1
`define MCCT_OFS_PRE_CNT 4'h2
`define MCCT_OFS_COUNT 4'h3
`define MCCT_OFS_CAPTURE 4'h4
`define MCCT_OFS_MATCH_CTRL 4'h5
`define MCCT_OFS_MATCH0 4'h6
// Global registers
`define MCCT_ADDR_INT_STATUS 12'h100
`define MCCT_ADDR_INT_CLEAR 12'h104
`define MCCT_ADDR_INT_ENABLE 12'h108
// Control register fields
`define MCCT_CTRL_RUN 0
`define MCCT_CTRL_CNT_MODE 1
`define MCCT_CTRL_CNT_EDGE 2
`define MCCT_CTRL_CAP_EDGE 4
`define MCCT_CTRL_CLR_EDGE 6
`define MCCT_CTRL_SOFT_RST 8
`define MCCT_CTRL_W 9
// Match control fields: stop [3:0], reset [7:4], output action [15:8]
`define MCCT_MCTL_STOP 0
`define MCCT_MCTL_RESET 4
`define MCCT_MCTL_OUT 8
`define MCCT_MCTL_W 16
// Output actions
`define MCCT_OUT_NONE 2'h0
`define MCCT_OUT_LOW 2'h1
`define MCCT_OUT_HIGH 2'h2
`define MCCT_OUT_TOGGLE 2'h3
// Edge selections
`define MCCT_EDGE_OFF 2'h0
`define MCCT_EDGE_RISE 2'h1
`define MCCT_EDGE_FALL 2'h2
`define MCCT_EDGE_BOTH 2'h3
// Interrupt status: 5 bits per timer, matches [3:0], capture [4]
`define MCCT_IRQ_PER_TMR 5
`define MCCT_IRQ_W 20
// Reset values
`define MCCT_RST_CTRL 9'h000
`define MCCT_RST_MCTL 16'h0000
`define MCCT_RST_WORD 32'h00000000
`endif

// ==== rtl/mcct_core.v ====
`include "mcct_consts.vh"
module mcct_core #(
    parameter W = 32
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Configuration
    input wire run,
    input wire cnt_mode,
    input wire [1:0] cnt_edge,
    input wire [1:0] cap_edge,
    input wire [1:0] clr_edge,
    input wire soft_rst,
    input wire [W-1:0] pre_max,
    input wire [3:0] stop_en,
    input wire [3:0] reset_en,
    input wire [7:0] out_act,
    input wire [4*W-1:0] match_val,
    // Synchronised capture pin
    input wire cap_sync,
    // State and events
    output reg [W-1:0] pre_r,
    output reg [W-1:0] count_r,
    output reg [W-1:0] capture_r,
    output reg [3:0] match_out_r,
    output reg [3:0] match_ev_r,
    output reg cap_ev_r,
    output reg stop_ev_r
);
    reg cap_d_r;
    wire rise = cap_sync & ~cap_d_r;
    wire fall = ~cap_sync & cap_d_r;

    // Edge selection helper
    function sel_edge;
        input [1:0] sel;
        input r;
        input f;
        begin
            sel_edge = (sel[0] & r) | (sel[1] & f);
        end
    endfunction

    wire cnt_hit = sel_edge(cnt_edge, rise, fall);
    wire cap_hit = sel_edge(cap_edge, rise, fall);
    wire clr_hit = sel_edge(clr_edge, rise, fall);
    wire adv = run & (cnt_mode ? cnt_hit : 1'b1);
    wire tick = adv & (pre_r == pre_max);
    wire [3:0] eq;
    genvar m;
    generate
        for (m = 0; m < 4; m = m + 1) begin : g_eq
            assign eq[m] = (count_r == match_val[m*W +: W]);
        end
    endgenerate
    wire [3:0] hit = eq & {4{tick}};
    wire do_reset = |(hit & reset_en);
    wire do_stop = |(hit & stop_en);

    // Prescaler and counter
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= {W{1'b0}};
            count_r <= {W{1'b0}};
        end else if (soft_rst || (run && clr_hit)) begin
            pre_r <= {W{1'b0}};
            count_r <= {W{1'b0}};
        end else if (tick) begin
            pre_r <= {W{1'b0}};
            if (do_reset) begin
                count_r <= {W{1'b0}};
            end else if (!do_stop) begin
                count_r <= count_r + {{(W-1){1'b0}}, 1'b1};
            end
        end else if (adv) begin
            pre_r <= pre_r + {{(W-1){1'b0}}, 1'b1};
        end
    end

    // Capture, events and match outputs
    integer i;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_d_r <= 1'b0;
            capture_r <= {W{1'b0}};
            match_out_r <= 4'h0;
            match_ev_r <= 4'h0;
            cap_ev_r <= 1'b0;
            stop_ev_r <= 1'b0;
        end else begin
            cap_d_r <= cap_sync;
            cap_ev_r <= cap_hit;
            if (cap_hit) begin
                capture_r <= count_r;
            end
            match_ev_r <= hit;
            stop_ev_r <= do_stop;
            for (i = 0; i < 4; i = i + 1) begin
                if (hit[i]) begin
                    case (out_act[2*i +: 2])
                        `MCCT_OUT_LOW: match_out_r[i] <= 1'b0;
                        `MCCT_OUT_HIGH: match_out_r[i] <= 1'b1;
                        `MCCT_OUT_TOGGLE: match_out_r[i] <= ~match_out_r[i];
                        default: match_out_r[i] <= match_out_r[i];
                    endcase
                end
            end
        end
    end
endmodule

// ==== bench/mcct_checker_asserts.sv ====
module mcct_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata_r,
    // Pins and interrupt
    input wire logic [3:0] cap_pin,
    input wire logic [15:0] match_pin,
    input wire logic irq_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////
    // Register port answers
    property p_rd_idle; reg_rdata_r != 32'h0 |-> $past(reg_rd); endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside the read answer cycle");
    property p_hole;
        reg_rd && (reg_addr == 12'h200 || reg_addr == 12'h104) |=> reg_rdata_r == 32'h0;
    endproperty
    a_hole: assert property (p_hole)
        else $error("unmapped or write-only place read nonzero");
    property p_narrow; reg_rd && reg_addr[11:7] == 5'h01 |=> reg_rdata_r[31:16] == 16'h0; endproperty
    a_narrow: assert property (p_narrow)
        else $error("narrow timer read shows upper bits");
    property p_rst_quiet; $rose(rst_b) |-> (match_pin == 16'h0 && irq_r == 1'b0) [*2]; endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs active while leaving reset");
    property p_ien_rb;
        reg_wr && reg_addr == 12'h108 ##1 reg_rd && reg_addr == 12'h108
        |=> reg_rdata_r == {12'h0, $past(reg_wdata[19:0], 2)};
    endproperty
    a_ien_rb: assert property (p_ien_rb)
        else $error("interrupt enable readback differs");
    property p_ctrl_rb;
        reg_wr && reg_addr == 12'h000 ##1 reg_rd && reg_addr == 12'h000
        |=> reg_rdata_r[7:1] == $past(reg_wdata[7:1], 2);
    endproperty
    a_ctrl_rb: assert property (p_ctrl_rb)
        else $error("control readback differs");
    property p_irq_off; reg_wr && reg_addr == 12'h108 && reg_wdata == 32'h0 |-> ##2 !irq_r; endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt stays high with all enables off");
    property p_irq_on;
        reg_wr && reg_addr == 12'h108 && reg_wdata[19:0] == 20'hFFFFF
        ##1 reg_rd && reg_addr == 12'h100 ##1 reg_rdata_r != 32'h0 |=> irq_r;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("interrupt low with enabled status set");
endmodule

// ==== bench/mcct_pin_model.sv ====
module mcct_pin_model (
    // Clock
    input wire logic sys_clk,
    // Levels asked for by the scenario
    input wire logic [3:0] want,
    // Capture pins towards the timers
    output logic [3:0] cap_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pin levels move just after a clock edge, unrelated to the count
    initial cap_pin = 4'h0;
    always @(posedge sys_clk) cap_pin <= want;
endmodule

// ==== bench/mcct_top_tb.sv ====
module mcct_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata_r;
    logic [3:0] cap_pin;
    logic [3:0] want = 4'h0;
    logic [15:0] match_pin;
    logic irq_r;
    logic [31:0] q;
    logic p;
    int n_fail = 0;
    int checks_done = 0;
    // Rows: address, write value, expected readback
    logic [75:0] rows [6] = '{{12'h004, 32'hFFFFFFFF, 32'hFFFFFFFF},
        {12'h044, 32'hFFFFFFFF, 32'hFFFFFFFF}, {12'h084, 32'hFFFFFFFF, 32'h0000FFFF},
        {12'h0C4, 32'hFFFFFFFF, 32'h0000FFFF}, {12'h200, 32'h12345678, 32'h0},
        {12'h104, 32'h0, 32'h0}};
    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;
    mcct_top mcct_top_i (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .cap_pin(cap_pin), .match_pin(match_pin), .irq_r(irq_r));
    mcct_pin_model mcct_pin_model_i (.sys_clk(sys_clk), .want(want), .cap_pin(cap_pin));
    ////////////////////////////////////////////////////////////////////////
    // Bus cycles and comparison
    task automatic wr0(input logic [11:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        wr0(a, d);
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [11:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata_r;
        @(posedge sys_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #400000;
        n_fail++;
        end_of_test;
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        foreach (rows[i]) begin
            wr(rows[i][75:64], rows[i][63:32]);
            rd(rows[i][75:64]);
            chk(q, rows[i][31:0]);
        end
        $display("test widths done");
        rd(12'h00C);
        chk(q, 32'h0);
        rd(12'h108);
        chk(q, 32'h0);
        $display("test reset values done");
        // Timer 0: reset on match 0 at 3, toggle output
        wr(12'h004, 32'h0);
        wr(12'h018, 32'h3);
        wr(12'h014, 32'h0310);
        wr(12'h000, 32'h1);
        repeat (10) @(posedge sys_clk);
        for (int i = 0; i < 5; i++) begin
            rd(12'h00C);
            chk({31'h0, q <= 32'h3}, 32'h1);
        end
        #1 p = match_pin[0];
        repeat (4) @(posedge sys_clk);
        #1 chk(match_pin[0], {31'h0, !p});
        @(posedge sys_clk);
        wr0(12'h108, 32'hFFFFF);
        rd(12'h100);
        chk(q[0], 1'b1);
        @(negedge sys_clk);
        chk(irq_r, 1'b1);
        @(posedge sys_clk);
        wr0(12'h108, 32'h0);
        rd(12'h108);
        chk(q, 32'h0);
        @(negedge sys_clk);
        chk(irq_r, 1'b0);
        @(posedge sys_clk);
        wr0(12'h000, 32'h0);
        rd(12'h000);
        chk(q, 32'h0);
        wr(12'h104, 32'hFFFFF);
        rd(12'h100);
        chk(q, 32'h0);
        $display("test match reset done");
        // Timer 1: stop on match 0 at 5, output high
        wr(12'h044, 32'h1);
        wr(12'h058, 32'h5);
        wr(12'h054, 32'h0201);
        wr(12'h040, 32'h1);
        repeat (30) @(posedge sys_clk);
        rd(12'h04C);
        chk(q, 32'h5);
        rd(12'h040);
        chk(q[0], 1'b0);
        chk(match_pin[4], 1'b1);
        $display("test match stop done");
        // Timer 2: clear on rise, capture on fall
        wr(12'h084, 32'h0);
        wr(12'h080, 32'h61);
        want[2] <= 1'b1;
        repeat (10) @(posedge sys_clk);
        want[2] <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rd(12'h090);
        chk({31'h0, q >= 32'h9 && q <= 32'hB}, 32'h1);
        rd(12'h100);
        chk(q[14], 1'b1);
        $display("test pulse width done");
        // Timer 3: counter mode on both edges
        wr(12'h0C4, 32'h0);
        wr(12'h0C0, 32'hF);
        for (int i = 0; i < 3; i++) begin
            want[3] <= 1'b1;
            repeat (4) @(posedge sys_clk);
            want[3] <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
        repeat (4) @(posedge sys_clk);
        rd(12'h0CC);
        chk(q, 32'h6);
        $display("test event count done");
        // Soft reset clears the count and drops itself
        wr(12'h0C0, 32'h10F);
        rd(12'h0C0);
        chk(q, 32'h0000000F);
        rd(12'h0CC);
        chk(q, 32'h0);
        $display("test soft reset done");
        end_of_test;
    end
endmodule
bind mcct_top mcct_checker mcct_checker_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .cap_pin(cap_pin), .match_pin(match_pin), .irq_r(irq_r));
